// ---- rtl/cwie_exec.sv ----
`timescale 1ns/1ns
`default_nettype none
module cwie_exec
  import cwie_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_instr_valid,
  input  wire cwie_op_t             i_instr_op,
  input  wire logic [PC_W-1:0]      i_pc,
  input  wire logic [PC_W-1:0]      i_call_addr,
  input  wire logic [DM_AW-1:0]     i_mem_addr,
  input  wire logic [BIT_SEL_W-1:0] i_bit_sel,
  input  wire logic                 i_timeout_set,
  input  wire logic                 i_power_down_set,
  output logic                      o_busy,
  output logic                      o_pc_load,
  output logic      [PC_W-1:0]      o_pc_target,
  output logic                      o_ret_valid,
  output logic      [PC_W-1:0]      o_ret_addr,
  output logic      [SP_W-1:0]      o_stack_ptr,
  output logic                      o_mem_we,
  output logic      [DM_AW-1:0]     o_mem_addr,
  output logic      [DW-1:0]        o_mem_wdata,
  output logic      [DW-1:0]        o_mem_wmask,
  output logic                      o_watchdog_counter_clear,
  output logic                      o_timeout_flag,
  output logic                      o_power_down_flag
);
  function automatic logic [PC_W-1:0] pc_next(input logic [PC_W-1:0] pc);
    pc_next = pc + PC_ONE;
  endfunction

  function automatic logic [DW-1:0] bit_mask(input logic [BIT_SEL_W-1:0] sel);
    bit_mask = MASK_BIT0 << sel;
  endfunction

  // reset release through two flops
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  cwie_phase_t     phase_ff;
  cwie_phase_t     nxt_phase;
  logic            accept;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] push_data;

  assign o_busy    = (phase_ff == CWIE_PH_CALL_LOAD);
  assign accept    = i_instr_valid && !o_busy;
  assign push      = accept && (i_instr_op == CWIE_OP_CALL);
  assign pop       = accept && (i_instr_op == CWIE_OP_RETURN);
  assign push_data = pc_next(i_pc); // RULE1

  // call sequencing and program counter load
  logic            pc_load_ff;
  logic            nxt_pc_load;
  logic [PC_W-1:0] target_ff;
  logic [PC_W-1:0] nxt_target;
  logic            ret_valid_ff;
  logic            nxt_ret_valid;

  always_comb begin
    nxt_phase     = CWIE_PH_IDLE;
    nxt_pc_load   = 1'b0;
    nxt_target    = target_ff;
    nxt_ret_valid = pop;
    unique case (phase_ff)
      CWIE_PH_IDLE: begin
        if (push) begin
          nxt_phase  = CWIE_PH_CALL_LOAD; // RULE2
          nxt_target = i_call_addr;
        end
      end
      CWIE_PH_CALL_LOAD: begin
        nxt_pc_load = 1'b1; // RULE2
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff     <= CWIE_PH_IDLE;
      pc_load_ff   <= 1'b0;
      target_ff    <= PC_RESET;
      ret_valid_ff <= 1'b0;
    end else begin
      phase_ff     <= nxt_phase;
      pc_load_ff   <= nxt_pc_load;
      target_ff    <= nxt_target;
      ret_valid_ff <= nxt_ret_valid;
    end
  end

  assign o_pc_load   = pc_load_ff;
  assign o_pc_target = target_ff;
  assign o_ret_valid = ret_valid_ff;

  cwie_stack u_stack (
    .i_clk       (i_mclk),
    .i_rst_n     (rst_n),
    .i_push      (push),
    .i_push_data (push_data),
    .i_pop       (pop),
    .o_pop_data  (o_ret_addr),
    .o_sp        (o_stack_ptr)
  );

  // data memory writes: masked so no read is needed
  logic             mem_we_ff;
  logic             nxt_mem_we;
  logic [DM_AW-1:0] mem_addr_ff;
  logic [DM_AW-1:0] nxt_mem_addr;
  logic [DW-1:0]    mem_mask_ff;
  logic [DW-1:0]    nxt_mem_mask;

  always_comb begin
    nxt_mem_we   = 1'b0;
    nxt_mem_addr = mem_addr_ff;
    nxt_mem_mask = MASK_NONE;
    if (accept && i_instr_op == CWIE_OP_BYTE_ZERO) begin
      nxt_mem_we   = 1'b1;
      nxt_mem_addr = i_mem_addr;
      nxt_mem_mask = MASK_ALL; // RULE3
    end else if (accept && i_instr_op == CWIE_OP_BIT_ZERO) begin
      nxt_mem_we   = 1'b1;
      nxt_mem_addr = i_mem_addr;
      nxt_mem_mask = bit_mask(i_bit_sel); // RULE4
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we_ff   <= 1'b0;
      mem_addr_ff <= ADDR_RESET;
      mem_mask_ff <= MASK_NONE;
    end else begin
      mem_we_ff   <= nxt_mem_we;
      mem_addr_ff <= nxt_mem_addr;
      mem_mask_ff <= nxt_mem_mask;
    end
  end

  assign o_mem_we    = mem_we_ff;
  assign o_mem_addr  = mem_addr_ff;
  assign o_mem_wmask = mem_mask_ff;
  assign o_mem_wdata = BYTE_ZERO_VAL; // RULE3 RULE4

  // watchdog clears and the two flags
  cwie_pre_t pre_ff;
  cwie_pre_t nxt_pre;
  logic      wdt_clr;
  logic      wdt_clr_ff;
  logic      timeout_ff;
  logic      nxt_timeout;
  logic      pdown_ff;
  logic      nxt_pdown;

  always_comb begin
    nxt_pre = pre_ff;
    wdt_clr = 1'b0;
    if (accept) begin
      unique case (i_instr_op)
        CWIE_OP_WDT_SINGLE: wdt_clr = 1'b1; // RULE5
        CWIE_OP_WDT_FIRST: begin
          if (pre_ff == CWIE_PRE_SECOND) begin
            wdt_clr = 1'b1; // RULE6
            nxt_pre = CWIE_PRE_NONE;
          end else begin
            nxt_pre = CWIE_PRE_FIRST; // RULE7
          end
        end
        CWIE_OP_WDT_SECOND: begin
          if (pre_ff == CWIE_PRE_FIRST) begin
            wdt_clr = 1'b1; // RULE6
            nxt_pre = CWIE_PRE_NONE;
          end else begin
            nxt_pre = CWIE_PRE_SECOND; // RULE7
          end
        end
        default: nxt_pre = pre_ff;
      endcase
    end
    // a set in the clearing cycle wins
    nxt_timeout = i_timeout_set || (timeout_ff && !wdt_clr); // RULE8
    nxt_pdown   = i_power_down_set || (pdown_ff && !wdt_clr); // RULE8
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff     <= CWIE_PRE_NONE;
      wdt_clr_ff <= 1'b0;
      timeout_ff <= FLAG_RESET;
      pdown_ff   <= FLAG_RESET;
    end else begin
      pre_ff     <= nxt_pre;
      wdt_clr_ff <= wdt_clr;
      timeout_ff <= nxt_timeout;
      pdown_ff   <= nxt_pdown;
    end
  end

  assign o_watchdog_counter_clear = wdt_clr_ff;
  assign o_timeout_flag           = timeout_ff;
  assign o_power_down_flag        = pdown_ff;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  sequence s_call_taken;
    accept && i_instr_op == CWIE_OP_CALL;
  endsequence

  sequence s_call_finish;
    o_busy && !o_pc_load ##1 !o_busy && o_pc_load;
  endsequence

  chk_call_push_value: assert property ( // RULE1
    s_call_taken |-> push && push_data == i_pc + PC_ONE)
    else $error("call did not push pc plus one");

  chk_call_two_cycle: assert property ( // RULE2
    s_call_taken |=> s_call_finish ##0 o_pc_target == $past(i_call_addr, 2))
    else $error("call did not load target on its second cycle");

  chk_byte_zero_wr: assert property ( // RULE3
    accept && i_instr_op == CWIE_OP_BYTE_ZERO |=> o_mem_we && o_mem_wmask == MASK_ALL
      && o_mem_wdata == BYTE_ZERO_VAL && o_mem_addr == $past(i_mem_addr))
    else $error("byte zero write wrong");

  chk_bit_zero_wr: assert property ( // RULE4
    accept && i_instr_op == CWIE_OP_BIT_ZERO |=> o_mem_we && $onehot(o_mem_wmask)
      && o_mem_wmask == (MASK_BIT0 << $past(i_bit_sel)) && o_mem_addr == $past(i_mem_addr))
    else $error("bit zero write wrong");

  chk_single_wdt_clear: assert property ( // RULE5
    accept && i_instr_op == CWIE_OP_WDT_SINGLE && !i_timeout_set && !i_power_down_set
      |=> o_watchdog_counter_clear && !o_timeout_flag && !o_power_down_flag)
    else $error("single watchdog clear missed");

  chk_pair_wdt_clear: assert property ( // RULE6
    accept && i_instr_op == CWIE_OP_WDT_SECOND && pre_ff == CWIE_PRE_FIRST
      && !i_timeout_set |=> o_watchdog_counter_clear && !o_timeout_flag)
    else $error("alternating pre-clear pair did not clear");

  chk_repeat_no_clear: assert property ( // RULE7
    accept && i_instr_op == CWIE_OP_WDT_FIRST && pre_ff != CWIE_PRE_SECOND
      |=> !o_watchdog_counter_clear)
    else $error("repeated pre-clear had an effect");

  chk_repeat_second: assert property ( // RULE7
    accept && i_instr_op == CWIE_OP_WDT_SECOND && pre_ff != CWIE_PRE_FIRST
      |=> !o_watchdog_counter_clear)
    else $error("repeated second pre-clear had an effect");

  chk_flags_hold: assert property ( // RULE8
    ($fell(o_timeout_flag) || $fell(o_power_down_flag)) |-> o_watchdog_counter_clear)
    else $error("flag cleared without a watchdog clear");
endmodule
`default_nettype wire

// ---- rtl/cwie_pkg.sv ----
// Contract
// (RULE1) a call pushes the program counter plus one onto the stack
// (RULE2) a call then loads the target address; it takes two instruction cycles
// (RULE3) byte zero clears every bit of the addressed location, flags untouched
// (RULE4) bit zero clears only the selected bit, other bits and flags untouched
// (RULE5) single watchdog clear resets the counter and zeroes both flags at once; the code keeps a flag that is set in the same cycle
// (RULE6) the two pre-clears act only as an alternating pair, then clear all; the code keeps a flag that is set in the same cycle
// (RULE7) repeating one pre-clear without the other changes nothing
// (RULE8) flags clear only on a watchdog clear, single or paired pre-clears, otherwise hold
// (RULE9) the return stack holds four entries; deeper calls overwrite the oldest
package cwie_pkg;
  localparam int         PC_W         = 11;
  localparam int         DM_AW        = 7;
  localparam int         DW           = 8;
  localparam int         BIT_SEL_W    = 3;
  localparam int         STACK_DEPTH  = 4;
  localparam int         SP_W         = 2;
  localparam logic [DW-1:0] BYTE_ZERO_VAL = 8'h00;
  localparam logic [DW-1:0] MASK_ALL      = 8'hff;
  localparam logic [DW-1:0] MASK_NONE     = 8'h00;
  localparam logic [DW-1:0] MASK_BIT0     = 8'h01;
  localparam logic [PC_W-1:0] PC_ONE      = 11'h001;
  localparam logic [PC_W-1:0] PC_RESET    = 11'h000;
  localparam logic [DM_AW-1:0] ADDR_RESET = 7'h00;
  localparam logic [SP_W-1:0] SP_RESET    = 2'h0;
  localparam logic [SP_W-1:0] SP_ONE      = 2'h1;
  localparam logic       FLAG_RESET   = 1'b0;

  typedef enum logic [2:0] {
    CWIE_OP_NONE,
    CWIE_OP_CALL,
    CWIE_OP_RETURN,
    CWIE_OP_BYTE_ZERO,
    CWIE_OP_BIT_ZERO,
    CWIE_OP_WDT_SINGLE,
    CWIE_OP_WDT_FIRST,
    CWIE_OP_WDT_SECOND
  } cwie_op_t;

  typedef enum logic {CWIE_PH_IDLE, CWIE_PH_CALL_LOAD} cwie_phase_t;

  typedef enum logic [1:0] {CWIE_PRE_NONE, CWIE_PRE_FIRST, CWIE_PRE_SECOND} cwie_pre_t;
endpackage

// ---- rtl/cwie_stack.sv ----
`timescale 1ns/1ns
`default_nettype none
module cwie_stack
  import cwie_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_push,
  input  wire logic [PC_W-1:0] i_push_data,
  input  wire logic            i_pop,
  output logic      [PC_W-1:0] o_pop_data,
  output logic      [SP_W-1:0] o_sp
);
  logic [PC_W-1:0] mem_ff [STACK_DEPTH];
  logic [SP_W-1:0] sp_ff;
  logic [SP_W-1:0] nxt_sp;
  logic [PC_W-1:0] rdata_ff;
  logic [PC_W-1:0] nxt_rdata;

  // pointer wraps: a fifth push overwrites the oldest entry
  always_comb begin
    nxt_sp    = sp_ff;
    nxt_rdata = rdata_ff;
    if (i_push) begin
      nxt_sp = sp_ff + SP_ONE; // RULE9
    end else if (i_pop) begin
      nxt_sp    = sp_ff - SP_ONE;
      nxt_rdata = mem_ff[sp_ff - SP_ONE];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp_ff    <= SP_RESET;
      rdata_ff <= PC_RESET;
    end else begin
      sp_ff    <= nxt_sp;
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_push) begin
      mem_ff[sp_ff] <= i_push_data; // RULE9
    end
  end

  assign o_pop_data = rdata_ff;
  assign o_sp       = sp_ff;

  chk_stack_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
    i_push |=> sp_ff == $past(sp_ff) + SP_ONE)
    else $error("stack pointer did not advance by one on push");
endmodule
`default_nettype wire

// ---- verification/cwie_exec_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module cwie_exec_tb
  import cwie_pkg::*;
;
  logic                 i_mclk;
  logic                 i_reset_n;
  logic                 i_instr_valid;
  cwie_op_t             i_instr_op;
  logic [PC_W-1:0]      i_pc;
  logic [PC_W-1:0]      i_call_addr;
  logic [DM_AW-1:0]     i_mem_addr;
  logic [BIT_SEL_W-1:0] i_bit_sel;
  logic                 i_timeout_set;
  logic                 i_power_down_set;
  logic                 o_busy;
  logic                 o_pc_load;
  logic [PC_W-1:0]      o_pc_target;
  logic                 o_ret_valid;
  logic [PC_W-1:0]      o_ret_addr;
  logic [SP_W-1:0]      o_stack_ptr;
  logic                 o_mem_we;
  logic [DM_AW-1:0]     o_mem_addr;
  logic [DW-1:0]        o_mem_wdata;
  logic [DW-1:0]        o_mem_wmask;
  logic                 o_watchdog_counter_clear;
  logic                 o_timeout_flag;
  logic                 o_power_down_flag;
  int                   failures = 0;
  int                   checked = 0;

  cwie_exec u_cwie_exec (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid),
    .i_instr_op(i_instr_op), .i_pc(i_pc), .i_call_addr(i_call_addr),
    .i_mem_addr(i_mem_addr), .i_bit_sel(i_bit_sel), .i_timeout_set(i_timeout_set),
    .i_power_down_set(i_power_down_set), .o_busy(o_busy), .o_pc_load(o_pc_load),
    .o_pc_target(o_pc_target), .o_ret_valid(o_ret_valid), .o_ret_addr(o_ret_addr),
    .o_stack_ptr(o_stack_ptr), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_mem_wmask(o_mem_wmask),
    .o_watchdog_counter_clear(o_watchdog_counter_clear),
    .o_timeout_flag(o_timeout_flag), .o_power_down_flag(o_power_down_flag)
  );

  always #4 i_mclk = ~i_mclk;

  task automatic results();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge i_mclk);
    #1;
  endtask

  // drives the request across one edge and leaves it asserted until the next issue or idle
  task automatic issue(input cwie_op_t op);
    i_instr_valid = 1'b1;
    i_instr_op    = op;
    step();
  endtask

  task automatic idle();
    i_instr_valid = 1'b0;
    i_instr_op    = CWIE_OP_NONE;
    step();
  endtask

  task automatic set_flags();
    i_timeout_set    = 1'b1;
    i_power_down_set = 1'b1;
    step();
    i_timeout_set    = 1'b0;
    i_power_down_set = 1'b0;
    cmp_bit(o_timeout_flag, 1'b1);
    cmp_bit(o_power_down_flag, 1'b1);
  endtask

  task automatic wd_check(input logic clr, input logic flag);
    cmp_bit(o_watchdog_counter_clear, clr);
    cmp_bit(o_timeout_flag, flag);
    cmp_bit(o_power_down_flag, flag);
  endtask

  task automatic test_call();
    logic [SP_W-1:0] sp0;
    sp0 = o_stack_ptr;
    i_pc = 11'h123;
    i_call_addr = 11'h456;
    issue(CWIE_OP_CALL);
    cmp_bit(o_busy, 1'b1);
    cmp_bit(o_pc_load, 1'b0);
    cmp_val(16'(o_stack_ptr), 16'(sp0 + 2'h1));
    i_mem_addr = 7'h11;
    issue(CWIE_OP_BYTE_ZERO);
    cmp_bit(o_pc_load, 1'b1);
    cmp_val(16'(o_pc_target), 16'h0456);
    cmp_bit(o_busy, 1'b0);
    cmp_bit(o_mem_we, 1'b0);
    issue(CWIE_OP_RETURN);
    cmp_bit(o_pc_load, 1'b0);
    cmp_bit(o_ret_valid, 1'b1);
    cmp_val(16'(o_ret_addr), 16'h0124);
    cmp_val(16'(o_stack_ptr), 16'(sp0));
    idle();
    cmp_bit(o_ret_valid, 1'b0);
  endtask

  // five nested calls: the fifth overwrites the oldest of four entries
  task automatic test_depth();
    for (int k = 0; k < 5; k++) begin
      i_pc = 11'(k * 16);
      i_call_addr = 11'h700;
      issue(CWIE_OP_CALL);
      idle();
    end
    for (int j = 0; j < 4; j++) begin
      issue(CWIE_OP_RETURN);
      cmp_val(16'(o_ret_addr), 16'((4 - j) * 16 + 1));
    end
    idle();
  endtask

  task automatic test_mem();
    set_flags();
    i_mem_addr = 7'h5a;
    issue(CWIE_OP_BYTE_ZERO);
    cmp_bit(o_mem_we, 1'b1);
    cmp_val(16'(o_mem_addr), 16'h005a);
    cmp_val(16'(o_mem_wmask), 16'h00ff);
    cmp_val(16'(o_mem_wdata), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      i_mem_addr = 7'(i + 3);
      i_bit_sel = 3'(i);
      issue(CWIE_OP_BIT_ZERO);
      cmp_bit(o_mem_we, 1'b1);
      cmp_val(16'(o_mem_addr), 16'(i + 3));
      cmp_val(16'(o_mem_wmask), 16'(8'h01 << i));
      cmp_val(16'(o_mem_wdata), 16'h0000);
    end
    idle();
    cmp_bit(o_mem_we, 1'b0);
    wd_check(1'b0, 1'b1);
  endtask

  task automatic test_watchdog();
    set_flags();
    issue(CWIE_OP_WDT_SINGLE);
    wd_check(1'b1, 1'b0);
    idle();
    cmp_bit(o_watchdog_counter_clear, 1'b0);
    set_flags();
    issue(CWIE_OP_WDT_FIRST);
    wd_check(1'b0, 1'b1);
    issue(CWIE_OP_WDT_FIRST);
    wd_check(1'b0, 1'b1);
    issue(CWIE_OP_WDT_SECOND);
    wd_check(1'b1, 1'b0);
    idle();
    set_flags();
    issue(CWIE_OP_WDT_SECOND);
    wd_check(1'b0, 1'b1);
    issue(CWIE_OP_WDT_SECOND);
    wd_check(1'b0, 1'b1);
    issue(CWIE_OP_WDT_FIRST);
    wd_check(1'b1, 1'b0);
    i_timeout_set = 1'b1;
    issue(CWIE_OP_WDT_SINGLE);
    i_timeout_set = 1'b0;
    cmp_bit(o_watchdog_counter_clear, 1'b1);
    cmp_bit(o_timeout_flag, 1'b1);
    cmp_bit(o_power_down_flag, 1'b0);
    set_flags();
    issue(CWIE_OP_WDT_FIRST);
    wd_check(1'b0, 1'b1);
    issue(CWIE_OP_BYTE_ZERO);
    wd_check(1'b0, 1'b1);
    issue(CWIE_OP_WDT_SECOND);
    wd_check(1'b1, 1'b0);
    idle();
  endtask

  initial begin
    #10000;
    failures++;
    results();
  end

  initial begin
    i_mclk = 1'b0;
    i_reset_n = 1'b0;
    i_instr_valid = 1'b0;
    i_instr_op = CWIE_OP_NONE;
    i_pc = 11'h000;
    i_call_addr = 11'h000;
    i_mem_addr = 7'h00;
    i_bit_sel = 3'h0;
    i_timeout_set = 1'b0;
    i_power_down_set = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
    cmp_bit(o_busy, 1'b0);
    wd_check(1'b0, 1'b0);
    i_reset_n = 1'b1;
    repeat (3) step();
    test_call();
    test_depth();
    test_mem();
    test_watchdog();
    results();
  end
endmodule
`default_nettype wire
